// ### rtl/cbt_defs.svh
// Purpose: constants of the clock and boot-timing controller
// Assumes: byte addresses on a 32-bit APB, one register per word
// Notes:   delays are counted in slow rc periods, not in clk cycles
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses
`define CBT_A_MODE      8'h00
`define CBT_A_XTAL      8'h04
`define CBT_A_TRIM      8'h08
`define CBT_A_MISC      8'h0c
`define CBT_A_STAT      8'h10

// reset values
`define CBT_MODE_RST    8'hf4
`define CBT_XTAL_RST    8'h00
`define CBT_TRIM_RST    8'h80
`define CBT_MISC_RST    8'h00

// field positions
`define CBT_XTAL_EN_BIT 7
`define CBT_FAST_EN_BIT 4
`define CBT_SLOW_EN_BIT 2
`define CBT_WDT_EN_BIT  2
`define CBT_ST_WDT_BIT  2

// clock mode codes
`define CBT_CM_DIV2     8'h34
`define CBT_CM_DIV4     8'h14
`define CBT_CM_DIV8     8'h3c
`define CBT_CM_DIV16    8'h1c
`define CBT_CM_DIV32    8'h7c
`define CBT_CM_SLOW     8'he4

// divider values
`define CBT_DV1         7'h01
`define CBT_DV2         7'h02
`define CBT_DV4         7'h04
`define CBT_DV8         7'h08
`define CBT_DV16        7'h10
`define CBT_DV32        7'h20
`define CBT_DV64        7'h40

// fast rc calibration target, for reference only
`define CBT_TRIM_TARGET_MHZ 16

// delays in slow rc periods
`define CBT_BOOT_FAST   19'h0002d
`define CBT_BOOT_NORM   19'h00bb8
`define CBT_WAKE_FAST   19'h0002d
`define CBT_WAKE_SLOW   19'h00bb8
`define CBT_WDT_0       19'h02000
`define CBT_WDT_1       19'h04000
`define CBT_WDT_2       19'h10000
`define CBT_WDT_3       19'h40000

`endif

// ### rtl/cbt_pkg.sv
// Purpose: types of the clock and boot-timing controller
// Assumes: constants live in cbt_defs.svh
// Notes:   state of each module is one packed struct
package cbt_pkg;

   typedef enum logic [1:0] {
      CBT_BOOT = 2'b00,
      CBT_RUN  = 2'b01,
      CBT_WAKE = 2'b10
   } cbt_state_e;

   typedef enum logic [1:0] {
      CBT_SRC_FAST = 2'b00,
      CBT_SRC_SLOW = 2'b01,
      CBT_SRC_XTAL = 2'b10
   } cbt_src_e;

   typedef struct packed {
      logic        active;
      logic [18:0] cnt;
      logic        done;
   } cbt_cnt_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [7:0]  clk_mode;
      logic [7:0]  xtal_ctl;
      logic [7:0]  trim;
      logic [7:0]  misc;
      cbt_src_e    src;
      logic [6:0]  div;
      logic        uncal;
      logic        wdt_flag;
      logic        started;
      cbt_state_e  state;
      logic        run;
      logic        wdt_expire;
      logic [2:0]  rc_sync;
      logic        rc_lvl;
   } cbt_top_s;

endpackage : cbt_pkg

// ### rtl/cbt_delay.sv
// Purpose: counts slow rc periods up to a limit and flags completion
// Assumes: tick is a one-cycle pulse per slow rc period, limit stable while active
// Notes:   done is a one-cycle pulse; start restarts, stop abandons
`timescale 1ns/1ns
module cbt_delay
   import cbt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        tick,
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic [18:0] limit,
   output logic             done
);

   cbt_cnt_s s_r;
   cbt_cnt_s s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // counts rc ticks from start, so the first period may be partial and done up to one period early
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (stop) begin
         s_nxt.active = 1'b0;
         s_nxt.cnt    = 19'h00000;
      end else if (start) begin
         s_nxt.active = 1'b1;
         s_nxt.cnt    = 19'h00000;
      end else if (s_r.active && tick) begin
         s_nxt.cnt = 19'(s_r.cnt + 19'h00001);
         if (s_nxt.cnt == limit) begin
            s_nxt.done   = 1'b1;
            s_nxt.active = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;

   done_count_a: assert property (@(posedge clk) disable iff (!rstn)
      done |-> $past(s_r.cnt) == 19'(limit - 19'h00001) && $past(tick))
      else $error("delay finished before its limit of slow periods");

endmodule : cbt_delay

// ### rtl/cbt_ctrl.sv
// Purpose: clock and boot-timing controller with an APB register port
// Assumes: straps and option pins are static; slow_rc_osc is the raw slow rc
// Notes:   no wait state on any APB access; outputs come from flip-flops
`timescale 1ns/1ns
`include "cbt_defs.svh"

module cbt_ctrl
   import cbt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire logic        slow_rc_osc,
   input  wire logic        fast_boot_opt,
   input  wire logic        fast_wake_opt,
   input  wire logic        cal_valid,
   input  wire logic [7:0]  cal_mode,
   input  wire logic        wake_req,
   input  wire logic        wdt_kick,
   output logic             xtal_osc_en,
   output logic             fast_rc_en,
   output logic             slow_rc_en,
   output logic [1:0]       system_clock_select_src,
   output logic [6:0]       system_clock_select_div,
   output logic [7:0]       fast_rc_trim,
   output logic             cpu_run,
   output logic             wdt_reset
);

   cbt_top_s    s_r;
   cbt_top_s    s_nxt;
   logic        boot_done;
   logic        wake_done;
   logic        wdt_done;
   logic        rc_tick;
   logic        boot_start;
   logic        wake_start;
   logic        wdt_on;
   logic        wdt_restart;
   logic [18:0] boot_lim;
   logic [18:0] wake_lim;
   logic [18:0] wdt_lim;
   logic        wr_done;

   ////////////////////////////////////////////////////////////////////////////////
   // clock mode code to {hit, source, divider}; unknown codes miss
   function automatic logic [9:0] cm_decode(input logic [7:0] code);
      case (code)
         `CBT_CM_DIV2:  cm_decode = {1'b1, CBT_SRC_FAST, `CBT_DV2};
         `CBT_CM_DIV4:  cm_decode = {1'b1, CBT_SRC_FAST, `CBT_DV4};
         `CBT_CM_DIV8:  cm_decode = {1'b1, CBT_SRC_FAST, `CBT_DV8};
         `CBT_CM_DIV16: cm_decode = {1'b1, CBT_SRC_FAST, `CBT_DV16};
         `CBT_CM_DIV32: cm_decode = {1'b1, CBT_SRC_FAST, `CBT_DV32};
         `CBT_CM_SLOW:  cm_decode = {1'b1, CBT_SRC_SLOW, `CBT_DV1};
         default:       cm_decode = 10'h000;
      endcase
   endfunction : cm_decode

   ////////////////////////////////////////////////////////////////////////////////
   // timing requests toward the three slow rc counters
   assign rc_tick     = s_nxt.rc_lvl && !s_r.rc_lvl;
   assign boot_start  = !s_r.started;
   assign wake_start  = (s_r.state == CBT_RUN) && wake_req;
   assign wdt_on      = s_r.misc[`CBT_WDT_EN_BIT];
   assign wdt_restart = wdt_kick || s_r.wdt_expire || (wdt_on && !s_r.started);
   assign wr_done     = psel && penable && s_r.pready && pwrite && !s_r.pslverr;

   // option pins are straps, so the limits stay put while a count runs
   assign boot_lim = fast_boot_opt ? `CBT_BOOT_FAST : `CBT_BOOT_NORM;
   assign wake_lim = fast_wake_opt ? `CBT_WAKE_FAST : `CBT_WAKE_SLOW;

   always_comb begin
      case (s_r.misc[1:0])
         2'h0:    wdt_lim = `CBT_WDT_0;
         2'h1:    wdt_lim = `CBT_WDT_1;
         2'h2:    wdt_lim = `CBT_WDT_2;
         default: wdt_lim = `CBT_WDT_3;
      endcase
   end

   cbt_delay u_boot (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (rc_tick),
      .start (boot_start),
      .stop  (1'b0),
      .limit (boot_lim),
      .done  (boot_done)
   );

   cbt_delay u_wake (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (rc_tick),
      .start (wake_start),
      .stop  (1'b0),
      .limit (wake_lim),
      .done  (wake_done)
   );

   // restarts on kick, expiry or misc write; stop sees the enable being written
   cbt_delay u_wdt (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (rc_tick),
      .start (wdt_restart || (wr_done && paddr == `CBT_A_MISC)),
      .stop  (!s_nxt.misc[`CBT_WDT_EN_BIT]),
      .limit (wdt_lim),
      .done  (wdt_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state: apb slave, clock selection, boot and wake sequencing
   always_comb begin
      logic [9:0] dec;
      dec   = 10'h000;
      s_nxt = s_r;

      // slow rc sampled through three flops; level moves once two agree
      s_nxt.rc_sync = {s_r.rc_sync[1:0], slow_rc_osc};
      if (s_r.rc_sync[1] == s_r.rc_sync[2]) begin
         s_nxt.rc_lvl = s_r.rc_sync[2];
      end

      s_nxt.started    = 1'b1;
      s_nxt.wdt_expire = wdt_done;
      if (wdt_done) begin
         s_nxt.wdt_flag = 1'b1;
      end

      // setup cycle latches the answer so pready and prdata leave flops
      s_nxt.pready = psel && !penable;
      if (psel && !penable) begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata  = 32'h00000000;
         case (paddr)
            `CBT_A_MODE: s_nxt.prdata[7:0] = s_r.clk_mode;
            `CBT_A_XTAL: s_nxt.prdata[7:0] = s_r.xtal_ctl;
            `CBT_A_TRIM: s_nxt.prdata[7:0] = s_r.trim;
            `CBT_A_MISC: s_nxt.prdata[7:0] = s_r.misc;
            `CBT_A_STAT: s_nxt.prdata[5:0] = {s_r.src, s_r.uncal, s_r.wdt_flag,
                                              s_r.state == CBT_WAKE, s_r.run};
            default:     s_nxt.pslverr = 1'b1;
         endcase
      end

      if (wr_done) begin
         case (paddr)
            `CBT_A_MODE: begin
               s_nxt.clk_mode = pwdata[7:0];
               dec            = cm_decode(pwdata[7:0]);
               // new source takes effect on this very write
               if (dec[9]) begin
                  s_nxt.src   = cbt_src_e'(dec[8:7]);
                  s_nxt.div   = dec[6:0];
                  s_nxt.uncal = 1'b0;
               end
            end
            `CBT_A_XTAL: s_nxt.xtal_ctl = pwdata[7:0];
            `CBT_A_TRIM: s_nxt.trim     = pwdata[7:0];
            `CBT_A_MISC: s_nxt.misc     = pwdata[7:0];
            `CBT_A_STAT: begin
               // a new expiry in the same cycle keeps the flag set
               if (pwdata[`CBT_ST_WDT_BIT] && !wdt_done) begin
                  s_nxt.wdt_flag = 1'b0;
               end
            end
            default: s_nxt.misc = s_r.misc;
         endcase
      end

      case (s_r.state)
         CBT_BOOT: begin
            s_nxt.run = 1'b0;
            if (boot_done) begin
               s_nxt.state = CBT_RUN;
               s_nxt.run   = 1'b1;
               if (cal_valid) begin
                  dec            = cm_decode(cal_mode);
                  s_nxt.clk_mode = cal_mode;
                  s_nxt.src      = cbt_src_e'(dec[8:7]);
                  s_nxt.div      = dec[6:0];
               end else begin
                  // mode register untouched; fallback source by boot speed
                  s_nxt.uncal = 1'b1;
                  s_nxt.src   = fast_boot_opt ? CBT_SRC_FAST : CBT_SRC_SLOW;
                  s_nxt.div   = fast_boot_opt ? `CBT_DV64 : `CBT_DV1;
               end
            end
         end
         CBT_RUN: begin
            if (wake_start) begin
               s_nxt.state = CBT_WAKE;
               s_nxt.run   = 1'b0;
            end
         end
         CBT_WAKE: begin
            if (wake_done) begin
               s_nxt.state = CBT_RUN;
               s_nxt.run   = 1'b1;
            end
         end
         default: s_nxt.state = CBT_BOOT;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r          <= '0;
         s_r.clk_mode <= `CBT_MODE_RST;
         s_r.xtal_ctl <= `CBT_XTAL_RST;
         s_r.trim     <= `CBT_TRIM_RST;
         s_r.misc     <= `CBT_MISC_RST;
         s_r.src      <= CBT_SRC_SLOW;
         s_r.div      <= `CBT_DV1;
         s_r.state    <= CBT_BOOT;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state flops
   assign pready       = s_r.pready;
   assign pslverr      = s_r.pslverr;
   assign prdata       = s_r.prdata;
   assign xtal_osc_en  = s_r.xtal_ctl[`CBT_XTAL_EN_BIT];
   assign fast_rc_en   = s_r.clk_mode[`CBT_FAST_EN_BIT];
   assign slow_rc_en   = s_r.clk_mode[`CBT_SLOW_EN_BIT];
   assign system_clock_select_src   = s_r.src;
   assign system_clock_select_div   = s_r.div;
   assign fast_rc_trim = s_r.trim;
   assign cpu_run      = s_r.run;
   assign wdt_reset    = s_r.wdt_expire;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   xtal_enable_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_done && paddr == `CBT_A_XTAL |=> xtal_osc_en == $past(pwdata[7]))
      else $error("crystal enable does not follow its control bit");

   div2_select_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_done && paddr == `CBT_A_MODE && pwdata[7:0] == `CBT_CM_DIV2
      |=> system_clock_select_src == CBT_SRC_FAST && system_clock_select_div == `CBT_DV2)
      else $error("mode 34h did not give fast rc divided by 2");

   div32_select_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_done && paddr == `CBT_A_MODE && pwdata[7:0] == `CBT_CM_DIV32
      |=> system_clock_select_src == CBT_SRC_FAST && system_clock_select_div == `CBT_DV32)
      else $error("mode 7ch did not give fast rc divided by 32");

   slow_select_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_done && paddr == `CBT_A_MODE && pwdata[7:0] == `CBT_CM_SLOW
      |=> system_clock_select_src == CBT_SRC_SLOW && system_clock_select_div == `CBT_DV1)
      else $error("mode e4h did not give undivided slow rc");

   boot_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      s_r.state == CBT_BOOT |-> !cpu_run)
      else $error("execution allowed during boot delay");

   wdt_limit_a: assert property (@(posedge clk) disable iff (!rstn)
      s_r.misc[1:0] == 2'h3 |-> wdt_lim == 19'h40000)
      else $error("watchdog field 11 does not select 262144 periods");

   wake_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      wake_start |=> !cpu_run ##0 s_r.state == CBT_WAKE)
      else $error("execution not held at wake-up");

   trim_write_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_done && paddr == `CBT_A_TRIM |=> fast_rc_trim == $past(pwdata[7:0]))
      else $error("trim write lost");

   uncal_keep_a: assert property (@(posedge clk) disable iff (!rstn)
      s_r.state == CBT_BOOT && boot_done && !cal_valid
      |=> s_r.clk_mode == $past(s_r.clk_mode) && cpu_run)
      else $error("uncalibrated boot altered the mode register");

endmodule : cbt_ctrl

// ### dv/tb_top.sv
// Purpose: self-checking bench of the clock and boot-timing controller
// Assumes: slow rc modelled as clk/4; fast straps first, then a calibrated slow-strap reset
// Notes:   delays are measured in slow rc rising edges counted by the bench
`timescale 1ns/1ns
`include "cbt_defs.svh"
module tb_top
   import cbt_pkg::*;
;
   logic        clk = 1'b0;
   logic        rstn, psel, penable, pwrite, wake_req, wdt_kick;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, xtal_osc_en, fast_rc_en, slow_rc_en, cpu_run, wdt_reset;
   logic [1:0]  system_clock_select_src;
   logic [6:0]  system_clock_select_div;
   logic [7:0]  fast_rc_trim;
   logic [1:0]  rc_div = 2'h1; // phase chosen so the slow rc falls at the release edge
   logic        boot_opt = 1'b1, wake_opt = 1'b1, cal_on = 1'b0;
   logic [7:0]  cal_code = 8'h00;
   int          slow_edges = 0, wdt_cnt = 0, wdt_at = 0, error_cnt = 0, checked = 0;
   localparam logic [7:0] CODES [6] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4};
   localparam logic [6:0] DIVS [6]  = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h01};

   cbt_ctrl i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .slow_rc_osc(rc_div[1]), .fast_boot_opt(boot_opt), .fast_wake_opt(wake_opt),
      .cal_valid(cal_on), .cal_mode(cal_code), .wake_req(wake_req), .wdt_kick(wdt_kick),
      .xtal_osc_en(xtal_osc_en), .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en),
      .system_clock_select_src(system_clock_select_src), .system_clock_select_div(system_clock_select_div), .fast_rc_trim(fast_rc_trim),
      .cpu_run(cpu_run), .wdt_reset(wdt_reset));

   ////////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock; slow rc is clk/4 so long counts stay affordable
   always #2 clk = ~clk;
   always @(posedge clk) begin
      rc_div <= rc_div + 2'h1;
      if (rc_div == 2'h1) slow_edges <= slow_edges + 1;
   end
   // timeout pulses sampled mid-cycle to stay clear of the launching edge
   always @(negedge clk) begin
      if (wdt_reset === 1'b1) begin
         wdt_cnt++;
         wdt_at = slow_edges;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // answer read as it stood at the rising edge that samples pready high
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(negedge clk);
   endtask : wr

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(name, r, exp);
   endtask : rd_chk

   // the sync delay of the slow rc leaves a window of edges, never a wider one
   task automatic wait_run(input string name, input int base, input int lo, input int hi);
      int k;
      k = 0;
      while (cpu_run !== 1'b1 && k < hi * 4 + 60) begin
         @(negedge clk);
         k++;
      end
      chk(name, (slow_edges - base >= lo) && (slow_edges - base <= hi), 1);
   endtask : wait_run

   task automatic wait_wdt(input int base, input int cnt);
      int k;
      k = 0;
      while (wdt_cnt < cnt && k < 33200) begin
         @(negedge clk);
         k++;
      end
      chk("wdt_period", (wdt_at - base >= 8191) && (wdt_at - base <= 8193), 1);
   endtask : wait_wdt

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_boot;
      int base;
      base = slow_edges;
      @(negedge clk);
      chk("xtal_osc_en", xtal_osc_en, 0);
      chk("fast_rc_en", fast_rc_en, 1);
      chk("slow_rc_en", slow_rc_en, 1);
      chk("fast_rc_trim", fast_rc_trim, 8'h80);
      chk("cpu_run", cpu_run, 0);
      wait_run("boot_delay", base, 45, 46);
      repeat (2) @(negedge clk);
      chk("system_clock_select_src", system_clock_select_src, CBT_SRC_FAST);
      chk("system_clock_select_div", system_clock_select_div, 7'h40);
      rd_chk("mode_reg", `CBT_A_MODE, 32'hf4);
   endtask : t_boot

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      wr(`CBT_A_TRIM, 32'h5a);
      chk("fast_rc_trim", fast_rc_trim, 8'h5a);
      rd_chk("trim_reg", `CBT_A_TRIM, 32'h5a);
      wr(`CBT_A_XTAL, 32'h80);
      chk("xtal_osc_en", xtal_osc_en, 1);
      chk("fast_rc_en", fast_rc_en, 1);
      wr(`CBT_A_XTAL, 32'h7f);
      chk("xtal_osc_en", xtal_osc_en, 0);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("unmapped_err", e, 1);
      chk("unmapped_data", r, 0);
   endtask : t_regs

   // every selection code, back to back, then an unknown code keeps the source
   task automatic t_modes;
      for (int i = 0; i < 6; i++) begin
         wr(`CBT_A_MODE, {24'h0, CODES[i]});
         chk("system_clock_select_div", system_clock_select_div, DIVS[i]);
         chk("system_clock_select_src", system_clock_select_src, (i == 5) ? CBT_SRC_SLOW : CBT_SRC_FAST);
         chk("fast_rc_en", fast_rc_en, CODES[i][4]);
         chk("slow_rc_en", slow_rc_en, CODES[i][2]);
      end
      wr(`CBT_A_MODE, 32'ha6);
      chk("system_clock_select_src", system_clock_select_src, CBT_SRC_SLOW);
      chk("system_clock_select_div", system_clock_select_div, 7'h01);
      chk("fast_rc_en", fast_rc_en, 0);
   endtask : t_modes

   task automatic t_wake;
      int base;
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      base = slow_edges;
      repeat (2) @(negedge clk);
      chk("cpu_run", cpu_run, 0);
      wait_run("wake_delay", base, 44, 46);
   endtask : t_wake

   // timeout, sticky flag and its clear, then a kick must push the next timeout out
   task automatic t_wdt;
      logic [31:0] r;
      logic        e;
      int          base;
      wr(`CBT_A_MISC, 32'h04);
      base = slow_edges;
      rd_chk("misc_reg", `CBT_A_MISC, 32'h04);
      wait_wdt(base, 1);
      apb(1'b0, `CBT_A_STAT, 32'h0, r, e);
      chk("wdt_flag", r[2], 1);
      apb(1'b1, `CBT_A_STAT, 32'h04, r, e);
      apb(1'b0, `CBT_A_STAT, 32'h0, r, e);
      chk("wdt_flag_clr", r[2], 0);
      base = slow_edges;
      while (slow_edges < base + 500) @(negedge clk);
      @(posedge clk);
      wdt_kick <= 1'b1;
      @(posedge clk);
      wdt_kick <= 1'b0;
      wait_wdt(slow_edges, 2);
   endtask : t_wdt

   // mid-run reset into a calibrated normal boot, then a slow wake-up
   task automatic t_cal;
      logic [31:0] r;
      logic        e;
      int          base;
      @(posedge clk);
      rstn     <= 1'b0;
      boot_opt <= 1'b0;
      wake_opt <= 1'b0;
      cal_on   <= 1'b1;
      cal_code <= `CBT_CM_DIV8;
      repeat (3) @(posedge clk);
      do @(posedge clk); while (rc_div != 2'h3);
      rstn <= 1'b1;
      base = slow_edges;
      @(negedge clk);
      chk("fast_rc_trim", fast_rc_trim, `CBT_TRIM_RST);
      chk("system_clock_select_src", system_clock_select_src, CBT_SRC_SLOW);
      chk("cpu_run", cpu_run, 0);
      wait_run("boot_norm", base, 3000, 3001);
      repeat (2) @(negedge clk);
      chk("system_clock_select_src", system_clock_select_src, CBT_SRC_FAST);
      chk("system_clock_select_div", system_clock_select_div, `CBT_DV8);
      rd_chk("mode_reg", `CBT_A_MODE, 32'h3c);
      apb(1'b0, `CBT_A_STAT, 32'h0, r, e);
      chk("uncal_flag", r[3], 0);
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      base = slow_edges;
      @(negedge clk);
      chk("cpu_run", cpu_run, 0);
      wait_run("wake_slow", base, 2999, 3001);
   endtask : t_cal

   ////////////////////////////////////////////////////////////////////////////////
   // reset released while the slow rc is low so no false edge is counted
   initial begin
      {rstn, psel, penable, pwrite, wake_req, wdt_kick} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_boot();
      t_regs();
      t_modes();
      t_wake();
      t_wdt();
      t_cal();
      report_and_stop();
   end

   // hang guard, a little beyond the sum of all scenario waits
   initial begin
      #390000;
      error_cnt++;
      report_and_stop();
   end
endmodule : tb_top
